// ---- logic/cplbc_core.sv ----
/*
 * Co-processor logic/branch core: AND in register and split immediate
 * forms, signed less-than branch, active channel and priority tracking,
 * and the initial stack pointer map, behind a classic Wishbone slave.
 * Assumes one 50 MHz clock, synchronous reset and requests synchronous to it.
 */
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
`include "cplbc_params.svh"
module cplbc_core #(
    parameter int DW = 16,
    parameter int CHW = 7,
    parameter int PLW = 3,
    parameter int SPN = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic req_valid_i,
    input wire logic [CHW-1:0] req_channel_i,
    input wire logic [PLW-1:0] req_level_i,
    output logic req_grant_o,
    output logic thread_active_o,
    output logic [CHW-1:0] channel_id_o,
    output logic [PLW-1:0] priority_level_o,
    output logic debug_mode_o
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic cplbc_pkg::cplbc_op_e decode_op(input logic [15:0] w);
        if (w[15:11] == `CPLBC_OPC_TRI && w[1:0] == 2'b00)
            return cplbc_pkg::CPLBC_OP_TRI;
        else if (w[15:11] == `CPLBC_OPC_AND_LOW_BYTE)
            return cplbc_pkg::CPLBC_OP_AND_LOW_BYTE;
        else if (w[15:11] == `CPLBC_OPC_AND_HIGH_BYTE)
            return cplbc_pkg::CPLBC_OP_AND_HIGH_BYTE;
        else if (w[15:9] == `CPLBC_OPC_BLT)
            return cplbc_pkg::CPLBC_OP_BLT;
        else
            return cplbc_pkg::CPLBC_OP_NONE;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic pend_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [4:0] idx;
    logic is_gpr;
    logic wr_en;
    cplbc_pkg::cplbc_state_e st_q;

    assign idx = wb_adr_i[6:2];
    assign is_gpr = (wb_adr_i[7] == 1'b0) && (idx[4:3] == `CPLBC_GPR_TAG);
    // A write lands on the edge at which the master samples the acknowledge.
    assign wr_en = ack_q && wb_cyc_i && wb_stb_i && wb_we_i;

    // Requests wait while an instruction runs, which keeps the read port free.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else
        begin
            pend_q <= wb_cyc_i && wb_stb_i && !pend_q && !ack_q
                      && (st_q == cplbc_pkg::CPLBC_ST_IDLE);
            ack_q <= pend_q;
        end
    end
    assign wb_ack_o = ack_q;

    // ------------------------------------------------------------------
    // Control, channel and priority state
    // ------------------------------------------------------------------
    logic debug_q;
    logic active_q;
    logic grant_q;
    logic [CHW-1:0] chid_q;
    logic [PLW-1:0] prio_q;
    logic req_wins;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            debug_q <= 1'b0;
        else if (wr_en && !wb_adr_i[7] && idx == `CPLBC_IDX_CTRL && wb_sel_i[0])
            debug_q <= wb_dat_i[`CPLBC_CTRL_DEBUG];
    end

    assign req_wins = req_valid_i && !debug_q && (!active_q || req_level_i > prio_q);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            active_q <= 1'b0;
            grant_q <= 1'b0;
            chid_q <= '0;
            prio_q <= '0;
        end
        else
        begin
            grant_q <= 1'b0;
            if (wr_en && !wb_adr_i[7] && wb_sel_i[0])
            begin
                if (idx == `CPLBC_IDX_CTRL && wb_dat_i[`CPLBC_CTRL_END])
                    active_q <= 1'b0;
                if (idx == `CPLBC_IDX_CTRL && debug_q && wb_dat_i[`CPLBC_CTRL_LAUNCH])
                    active_q <= 1'b1;
                if (idx == `CPLBC_IDX_CHID && debug_q)
                    chid_q <= wb_dat_i[CHW-1:0];
                if (idx == `CPLBC_IDX_PRIO && debug_q)
                    prio_q <= wb_dat_i[PLW-1:0];
            end
            // A winning request arriving with an end command still activates its channel.
            if (req_wins)
            begin
                active_q <= 1'b1;
                grant_q <= 1'b1;
                chid_q <= req_channel_i;
                prio_q <= req_level_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_grant_o <= 1'b0;
            thread_active_o <= 1'b0;
            channel_id_o <= '0;
            priority_level_o <= '0;
            debug_mode_o <= 1'b0;
        end
        else
        begin
            req_grant_o <= grant_q;
            thread_active_o <= active_q;
            channel_id_o <= chid_q;
            priority_level_o <= prio_q;
            debug_mode_o <= debug_q;
        end
    end

    // ------------------------------------------------------------------
    // Stack pointer select and mapped word
    // ------------------------------------------------------------------
    logic [2:0] spsel_q;
    logic [15:0] sp_q [SPN];
    logic [15:0] sp_map;

    assign sp_map = sp_q[spsel_q];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            spsel_q <= 3'h0;
        else if (wr_en && !wb_adr_i[7] && idx == `CPLBC_IDX_SPSEL && wb_sel_i[0])
            spsel_q <= wb_dat_i[2:0];
    end

    // Entry zero is the vector base; the others are initial stack pointers.
    for (genvar g = 0; g < SPN; g++)
    begin : g_sp
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                sp_q[g] <= `CPLBC_SP_RST;
            else if (wr_en && !wb_adr_i[7] && idx == `CPLBC_IDX_SPMAP && spsel_q == 3'(g))
                sp_q[g] <= merge16(sp_q[g], wb_dat_i, wb_sel_i);
        end
    end

    // ------------------------------------------------------------------
    // Instruction sequencer
    // ------------------------------------------------------------------
    logic [15:0] insn_q;
    logic [15:0] pc_q;
    logic [3:0] flags_q;
    logic hi_pend_q;
    logic [7:0] hi_imm_q;
    logic illegal_q;
    logic [15:0] rd_a;
    logic [15:0] rd_b;
    logic [15:0] res_d;
    logic [3:0] flags_d;
    logic [15:0] blt_tgt;
    logic mem_we;
    logic [2:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [2:0] raddr_a;
    cplbc_pkg::cplbc_op_e op;
    logic is_and;
    logic in_exec;
    logic insn_wr;
    logic imm_wr;

    assign op = decode_op(insn_q);
    assign is_and = op == cplbc_pkg::CPLBC_OP_TRI || op == cplbc_pkg::CPLBC_OP_AND_LOW_BYTE
                    || op == cplbc_pkg::CPLBC_OP_AND_HIGH_BYTE;
    assign in_exec = st_q == cplbc_pkg::CPLBC_ST_EXEC;
    assign insn_wr = wr_en && !wb_adr_i[7] && idx == `CPLBC_IDX_INSN;
    assign imm_wr = wr_en && !wb_adr_i[7] && idx == `CPLBC_IDX_SIXTEEN_BIT_IMMEDIATE;
    assign blt_tgt = pc_q + {{6{insn_q[8]}}, insn_q[8:0], 1'b0};

    always_comb
    begin
        res_d = rd_a;
        flags_d = flags_q;
        case (op)
            cplbc_pkg::CPLBC_OP_TRI:
            begin
                res_d = rd_a & rd_b;
                flags_d[`CPLBC_FLAG_Z] = res_d == 16'h0000;
            end
            cplbc_pkg::CPLBC_OP_AND_LOW_BYTE:
            begin
                res_d = {rd_a[15:8], rd_a[7:0] & insn_q[7:0]};
                flags_d[`CPLBC_FLAG_Z] = res_d[7:0] == 8'h00;
            end
            cplbc_pkg::CPLBC_OP_AND_HIGH_BYTE:
            begin
                res_d = {rd_a[15:8] & insn_q[7:0], rd_a[7:0]};
                flags_d[`CPLBC_FLAG_Z] = res_d[15:8] == 8'h00;
            end
            default:
            begin
                res_d = rd_a;
            end
        endcase
        if (is_and)
        begin
            flags_d[`CPLBC_FLAG_N] = res_d[15];
            flags_d[`CPLBC_FLAG_V] = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= cplbc_pkg::CPLBC_ST_IDLE;
            insn_q <= 16'h0000;
            hi_pend_q <= 1'b0;
            hi_imm_q <= 8'h00;
        end
        else
        begin
            case (st_q)
                cplbc_pkg::CPLBC_ST_IDLE:
                begin
                    if (insn_wr)
                    begin
                        insn_q <= merge16(insn_q, wb_dat_i, wb_sel_i);
                        st_q <= cplbc_pkg::CPLBC_ST_READ;
                    end
                    else if (imm_wr)
                    begin
                        insn_q <= {`CPLBC_OPC_AND_LOW_BYTE, wb_dat_i[`CPLBC_SIXTEEN_BIT_IMMEDIATE_RD_LSB+:3],
                                   wb_dat_i[7:0]};
                        hi_imm_q <= wb_dat_i[15:8];
                        hi_pend_q <= 1'b1;
                        st_q <= cplbc_pkg::CPLBC_ST_READ;
                    end
                end
                cplbc_pkg::CPLBC_ST_READ:
                    st_q <= cplbc_pkg::CPLBC_ST_EXEC;
                cplbc_pkg::CPLBC_ST_EXEC:
                begin
                    if (hi_pend_q)
                    begin
                        insn_q <= {`CPLBC_OPC_AND_HIGH_BYTE, insn_q[10:8], hi_imm_q};
                        hi_pend_q <= 1'b0;
                        st_q <= cplbc_pkg::CPLBC_ST_READ;
                    end
                    else
                        st_q <= cplbc_pkg::CPLBC_ST_IDLE;
                end
                default:
                    st_q <= cplbc_pkg::CPLBC_ST_IDLE;
            endcase
        end
    end

    // Bus writes and execution never overlap, so both may own these.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_q <= `CPLBC_PC_RST;
            flags_q <= `CPLBC_FLAGS_RST;
            illegal_q <= 1'b0;
        end
        else if (in_exec)
        begin
            flags_q <= flags_d;
            illegal_q <= op == cplbc_pkg::CPLBC_OP_NONE;
            if (op == cplbc_pkg::CPLBC_OP_BLT
                && (flags_q[`CPLBC_FLAG_N] ^ flags_q[`CPLBC_FLAG_V]))
                pc_q <= blt_tgt;
            else
                pc_q <= pc_q + `CPLBC_PC_STEP;
        end
        else if (wr_en && !wb_adr_i[7] && idx == `CPLBC_IDX_FLAGS && wb_sel_i[0])
            flags_q <= wb_dat_i[3:0];
        else if (wr_en && !wb_adr_i[7] && idx == `CPLBC_IDX_PC)
            pc_q <= merge16(pc_q, wb_dat_i, wb_sel_i);
    end

    // ------------------------------------------------------------------
    // Register file and read data
    // ------------------------------------------------------------------
    assign raddr_a = (st_q == cplbc_pkg::CPLBC_ST_READ)
                     ? ((op == cplbc_pkg::CPLBC_OP_TRI) ? insn_q[7:5] : insn_q[10:8])
                     : idx[2:0];
    assign mem_we = (in_exec && is_and) || (wr_en && is_gpr);
    assign mem_waddr = in_exec ? insn_q[10:8] : idx[2:0];
    assign mem_wdata = in_exec ? res_d : merge16(rd_a, wb_dat_i, wb_sel_i);

    cplbc_gpr_mem #(.DW(DW), .AW(3)) u_gpr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_a_i(raddr_a),
        .rdata_a_o(rd_a),
        .raddr_b_i(insn_q[4:2]),
        .rdata_b_o(rd_b)
    );

    // Unmapped addresses answer with zero and ignore writes.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_q <= 32'h00000000;
        else if (pend_q)
        begin
            dat_q <= 32'h00000000;
            if (is_gpr)
                dat_q <= {16'h0000, rd_a};
            else if (!wb_adr_i[7])
            begin
                case (idx)
                    `CPLBC_IDX_CTRL: dat_q <= {31'h0, debug_q};
                    `CPLBC_IDX_STAT: dat_q <= {29'h0, illegal_q, active_q,
                                               st_q != cplbc_pkg::CPLBC_ST_IDLE};
                    `CPLBC_IDX_CHID: dat_q <= {{(32-CHW){1'b0}}, chid_q};
                    `CPLBC_IDX_PRIO: dat_q <= {{(32-PLW){1'b0}}, prio_q};
                    `CPLBC_IDX_SPSEL: dat_q <= {29'h0, spsel_q};
                    `CPLBC_IDX_SPMAP: dat_q <= {16'h0000, sp_map};
                    `CPLBC_IDX_INSN: dat_q <= {16'h0000, insn_q};
                    `CPLBC_IDX_FLAGS: dat_q <= {28'h0, flags_q};
                    `CPLBC_IDX_PC: dat_q <= {16'h0000, pc_q};
                    default: dat_q <= 32'h00000000;
                endcase
            end
        end
    end
    assign wb_dat_o = dat_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [7:0] res_hi;
    logic [15:0] tri_and;
    assign res_hi = res_d[15:8];
    assign tri_and = rd_a & rd_b;

    sequence s_imm_write;
        imm_wr;
    endsequence
    sequence s_split_run;
        st_q == cplbc_pkg::CPLBC_ST_READ ##1 (in_exec && op == cplbc_pkg::CPLBC_OP_AND_LOW_BYTE)
        ##1 st_q == cplbc_pkg::CPLBC_ST_READ ##1 (in_exec && op == cplbc_pkg::CPLBC_OP_AND_HIGH_BYTE);
    endsequence

    a_tri_and_result: assert property (in_exec && op == cplbc_pkg::CPLBC_OP_TRI
        |-> mem_we && mem_wdata == tri_and) else $error("register AND result wrong");
    a_imm_split_order: assert property (s_imm_write |=> s_split_run)
        else $error("immediate AND not split in two steps");
    a_split_zero_flag: assert property (in_exec && op == cplbc_pkg::CPLBC_OP_AND_HIGH_BYTE
        |=> flags_q[`CPLBC_FLAG_Z] == ($past(res_hi) == 8'h00))
        else $error("high-byte zero flag wrong");
    a_and_neg_flag: assert property (in_exec && is_and
        |=> flags_q[`CPLBC_FLAG_N] == $past(res_d[15])) else $error("N flag wrong");
    a_tri_zero_flag: assert property (in_exec && op == cplbc_pkg::CPLBC_OP_TRI
        |=> flags_q[`CPLBC_FLAG_Z] == ($past(res_d) == 16'h0000))
        else $error("Z flag wrong");
    a_and_v_c: assert property (in_exec && is_and |=> !flags_q[`CPLBC_FLAG_V]
        && flags_q[`CPLBC_FLAG_C] == $past(flags_q[`CPLBC_FLAG_C]))
        else $error("V or C wrong after AND");
    a_blt_target: assert property (in_exec && op == cplbc_pkg::CPLBC_OP_BLT
        && (flags_q[`CPLBC_FLAG_N] ^ flags_q[`CPLBC_FLAG_V]) |=> pc_q == $past(blt_tgt))
        else $error("taken branch target wrong");
    a_blt_flags_kept: assert property (in_exec && op == cplbc_pkg::CPLBC_OP_BLT
        |=> $stable(flags_q)) else $error("branch changed flags");
    a_req_activate: assert property (req_wins |=> ##1 req_grant_o && thread_active_o
        && channel_id_o == $past(req_channel_i, 2) && priority_level_o == $past(req_level_i, 2))
        else $error("request did not activate channel");
endmodule // cplbc_core

// ---- logic/cplbc_gpr_mem.sv ----
/*
 * General register file: one write port, two read ports whose data come
 * out of registers. Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
module cplbc_gpr_mem #(
    parameter int DW = 16,
    parameter int AW = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_a_i,
    output logic [DW-1:0] rdata_a_o,
    input wire logic [AW-1:0] raddr_b_i,
    output logic [DW-1:0] rdata_b_o
);
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Write-first bypass so a read issued in the writing cycle sees new data.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_a_o <= '0;
            rdata_b_o <= '0;
        end
        else
        begin
            rdata_a_o <= (we_i && waddr_i == raddr_a_i) ? wdata_i : mem_q[raddr_a_i];
            rdata_b_o <= (we_i && waddr_i == raddr_b_i) ? wdata_i : mem_q[raddr_b_i];
        end
    end
endmodule // cplbc_gpr_mem

// ---- logic/cplbc_params.svh ----
/*
 * Offsets, field positions, reset values and opcode patterns of the
 * co-processor logic/branch core. Register offsets are word indexes; the
 * byte address on the bus is four times the index.
 */
`ifndef CPLBC_PARAMS_SVH
`define CPLBC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define CPLBC_IDX_CTRL 5'h00
`define CPLBC_IDX_STAT 5'h01
`define CPLBC_IDX_CHID 5'h02
`define CPLBC_IDX_PRIO 5'h03
`define CPLBC_IDX_SPSEL 5'h04
`define CPLBC_IDX_SPMAP 5'h06
`define CPLBC_IDX_INSN 5'h08
`define CPLBC_IDX_FLAGS 5'h09
`define CPLBC_IDX_PC 5'h0A
`define CPLBC_IDX_SIXTEEN_BIT_IMMEDIATE 5'h0B
`define CPLBC_GPR_TAG 2'b10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CPLBC_CTRL_DEBUG 0
`define CPLBC_CTRL_LAUNCH 1
`define CPLBC_CTRL_END 2
`define CPLBC_STAT_BUSY 0
`define CPLBC_STAT_ACTIVE 1
`define CPLBC_STAT_ILLEGAL 2
`define CPLBC_FLAG_N 3
`define CPLBC_FLAG_Z 2
`define CPLBC_FLAG_V 1
`define CPLBC_FLAG_C 0
`define CPLBC_SIXTEEN_BIT_IMMEDIATE_RD_LSB 16

// ----------------------------------------------------------------------
// Reset values and opcodes
// ----------------------------------------------------------------------
`define CPLBC_PC_RST 16'h0000
`define CPLBC_FLAGS_RST 4'h0
`define CPLBC_SP_RST 16'h0000
`define CPLBC_PC_STEP 16'h0002
`define CPLBC_OPC_TRI 5'h02
`define CPLBC_OPC_AND_LOW_BYTE 5'h10
`define CPLBC_OPC_AND_HIGH_BYTE 5'h11
`define CPLBC_OPC_BLT 7'h1B

`endif

// ---- logic/cplbc_pkg.sv ----
/*
 * Types of the co-processor logic/branch core.
 * Assumes cplbc_params.svh holds all numeric constants.
 */
package cplbc_pkg;

    // ------------------------------------------------------------------
    // Sequencer states, Gray coded along idle, read, execute
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CPLBC_ST_IDLE = 2'b00,
        CPLBC_ST_READ = 2'b01,
        CPLBC_ST_EXEC = 2'b11
    } cplbc_state_e;

    typedef enum logic [2:0] {
        CPLBC_OP_NONE = 3'h0,
        CPLBC_OP_TRI = 3'h1,
        CPLBC_OP_AND_LOW_BYTE = 3'h2,
        CPLBC_OP_AND_HIGH_BYTE = 3'h3,
        CPLBC_OP_BLT = 3'h4
    } cplbc_op_e;

endpackage

// ---- verif/cplbc_core_tb_top.sv ----
/*
 * Self-checking bench of the logic/branch core.
 * Assumes the register map and timing given with the core.
 */
`timescale 1ns/100ps
`include "cplbc_params.svh"
module cplbc_core_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic fire = 1'b0;
    logic [6:0] fch = 7'h00;
    logic [2:0] flv = 3'h0;
    logic [31:0] rdat;
    logic ack, rv, grant, act, dbg;
    logic [6:0] rch, chid;
    logic [2:0] rlv, prio;
    int bad_count = 0;
    int num_checks = 0;

    always #10 clk_i = ~clk_i;

    cplbc_req_model u_cplbc_req_model (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .ch_i(fch), .lvl_i(flv), .req_valid_o(rv), .req_channel_o(rch), .req_level_o(rlv));
    cplbc_core u_cplbc_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .req_valid_i(rv), .req_channel_i(rch), .req_level_i(rlv),
        .req_grant_o(grant), .thread_active_o(act), .channel_id_o(chid),
        .priority_level_o(prio), .debug_mode_o(dbg));

    // ------------------------------------------------------------------
    // Bus and comparison tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request stands until ack is seen at an edge or 40 edges pass, so an answer within 40 cycles is fine.
    task automatic wb(input logic w, input logic [4:0] idx, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, 1'b0, idx, 2'b00, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 40);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        if (ack !== 1'b1)
        begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 32'h0, q);
        chk(q, exp);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic and3(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] r;
        r = a & b;
        wr(5'h11, {16'h0, a});
        wr(5'h12, {16'h0, b});
        wr(`CPLBC_IDX_FLAGS, 32'h3);
        wr(`CPLBC_IDX_INSN, {16'h0, `CPLBC_OPC_TRI, 3'd3, 3'd1, 3'd2, 2'b00});
        rd(5'h13, {16'h0, r});
        rd(`CPLBC_IDX_FLAGS, {28'h0, r[15], r == 16'h0, 2'b01});
    endtask

    // Z must follow the high byte alone, so both byte patterns are tried.
    task automatic imm(input logic [15:0] a, input logic [15:0] i);
        logic [15:0] r;
        r = a & i;
        wr(5'h14, {16'h0, a});
        wr(`CPLBC_IDX_FLAGS, 32'h3);
        wr(`CPLBC_IDX_SIXTEEN_BIT_IMMEDIATE, {13'h0, 3'd4, i});
        rd(5'h14, {16'h0, r});
        rd(`CPLBC_IDX_FLAGS, {28'h0, r[15], r[15:8] == 8'h0, 2'b01});
    endtask

    task automatic branch_if_signed_less(input logic [3:0] fl, input logic [8:0] rel);
        logic [15:0] e;
        e = (fl[3] ^ fl[1]) ? 16'h0100 + {rel[8], rel[8], rel[8], rel[8], rel[8], rel[8],
            rel, 1'b0} : 16'h0102;
        wr(`CPLBC_IDX_PC, 32'h0100);
        wr(`CPLBC_IDX_FLAGS, {28'h0, fl});
        wr(`CPLBC_IDX_INSN, {16'h0, `CPLBC_OPC_BLT, rel});
        rd(`CPLBC_IDX_PC, {16'h0, e});
        rd(`CPLBC_IDX_FLAGS, {28'h0, fl});
    endtask

    task automatic req(input logic [6:0] ch, input logic [2:0] lvl, input logic g);
        logic seen;
        seen = 1'b0;
        @(posedge clk_i);
        {fire, fch, flv} <= {1'b1, ch, lvl};
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (4)
        begin
            @(posedge clk_i);
            if (grant === 1'b1)
                seen = 1'b1;
        end
        chk(seen, g);
    endtask

    task automatic t_dbg();
        wr(`CPLBC_IDX_CHID, 32'h55);
        rd(`CPLBC_IDX_CHID, 32'h0);
        wr(`CPLBC_IDX_CTRL, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(dbg, 1'b1);
        wr(`CPLBC_IDX_CHID, 32'h55);
        wr(`CPLBC_IDX_PRIO, 32'h5);
        rd(`CPLBC_IDX_CHID, 32'h55);
        rd(`CPLBC_IDX_PRIO, 32'h5);
        wr(`CPLBC_IDX_CTRL, 32'h3);
        repeat (2) @(posedge clk_i);
        chk({act, prio, chid}, {1'b1, 3'h5, 7'h55});
        req(7'h10, 3'h7, 1'b0);
        wr(`CPLBC_IDX_CTRL, 32'h4);
        repeat (2) @(posedge clk_i);
        chk(act, 1'b0);
        $display("test debug done");
    endtask

    task automatic t_map();
        wr(`CPLBC_IDX_SPSEL, 32'h0);
        wr(`CPLBC_IDX_SPMAP, 32'h1234);
        wr(`CPLBC_IDX_SPSEL, 32'h1);
        wr(`CPLBC_IDX_SPMAP, 32'h5678);
        wr(`CPLBC_IDX_SPSEL, 32'h0);
        rd(`CPLBC_IDX_SPMAP, 32'h1234);
        wr(`CPLBC_IDX_SPSEL, 32'h1);
        rd(`CPLBC_IDX_SPMAP, 32'h5678);
        rd(5'h05, 32'h0);
        $display("test map done");
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({act, prio, chid}, 11'h000);
        and3(16'hF0F0, 16'h8FF0);
        and3(16'h00FF, 16'hFF00);
        $display("test and done");
        imm(16'h8FF0, 16'hF00F);
        imm(16'h0FF3, 16'hF00F);
        $display("test imm done");
        branch_if_signed_less(4'h8, 9'h1FE);
        branch_if_signed_less(4'h2, 9'h0FF);
        branch_if_signed_less(4'hA, 9'h0FF);
        branch_if_signed_less(4'h5, 9'h0FF);
        $display("test branch done");
        t_dbg();
        req(7'h21, 3'h2, 1'b1);
        rd(`CPLBC_IDX_CHID, 32'h21);
        rd(`CPLBC_IDX_PRIO, 32'h2);
        req(7'h30, 3'h1, 1'b0);
        req(7'h7F, 3'h6, 1'b1);
        chk({prio, chid}, {3'h6, 7'h7F});
        $display("test request done");
        t_map();
        wr(`CPLBC_IDX_INSN, 32'h0000FFFF);
        rd(`CPLBC_IDX_STAT, 32'h00000006);
        $display("test status done");
        final_report();
    end
endmodule // cplbc_core_tb_top

// ---- verif/cplbc_req_model.sv ----
/*
 * Service request source standing in for the interrupt router.
 * Assumes the bench raises fire_i for one cycle per request.
 */
`timescale 1ns/100ps
module cplbc_req_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [6:0] ch_i,
    input wire logic [2:0] lvl_i,
    output logic req_valid_o,
    output logic [6:0] req_channel_o,
    output logic [2:0] req_level_o
);
    // Between requests the fields invert every cycle, so a core that samples
    // them one cycle late sees the inverse of the request rather than a lucky match.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            {req_valid_o, req_channel_o, req_level_o} <= 11'h000;
        else
            {req_valid_o, req_channel_o, req_level_o} <= fire_i ? {1'b1, ch_i, lvl_i}
                : {1'b0, ~req_channel_o, ~req_level_o};
    end
endmodule // cplbc_req_model
